// >>> src/bsi_map.svh
`ifndef BSI_MAP_SVH
`define BSI_MAP_SVH
// ****************************************************************
// Instruction register
// ****************************************************************
`define BSI_IR_W        4
`define BSI_IR_CAPTURE  4'h1
`define BSI_OP_EXTEST   4'h0
`define BSI_OP_SAMPLE   4'h3
`define BSI_OP_CLAMP    4'h5
`define BSI_OP_HIGHZ    4'h7
`define BSI_OP_CLAMPZ   4'h9
`define BSI_OP_INTEST   4'hc
`define BSI_OP_IDCODE   4'he
`define BSI_OP_BYPASS   4'hf
// ****************************************************************
// Identification word layout
// ****************************************************************
`define BSI_ID_W        32
`define BSI_ID_VER_MSB  31
`define BSI_ID_VER_LSB  28
`define BSI_ID_PART_MSB 27
`define BSI_ID_PART_LSB 12
`define BSI_ID_MAN_MSB  11
`define BSI_ID_MAN_LSB  1
`define BSI_ID_FIXED    1'b1
`define BSI_BYP_CAPTURE 1'b0
`endif

// >>> src/bsi_pkg.sv
package bsi_pkg;

  // ****************************************************************
  // Test access port states
  // ****************************************************************
  typedef enum logic [15:0] {
    TAP_RESET  = 16'h0001,
    TAP_IDLE   = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SH_DR  = 16'h0010,
    TAP_EX1_DR = 16'h0020,
    TAP_PA_DR  = 16'h0040,
    TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SH_IR  = 16'h0800,
    TAP_EX1_IR = 16'h1000,
    TAP_PA_IR  = 16'h2000,
    TAP_EX2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } bsi_tap_t;

  // ****************************************************************
  // Data register select and cell mode
  // ****************************************************************
  typedef enum logic [2:0] {
    SEL_BYP   = 3'h1,
    SEL_ID    = 3'h2,
    SEL_CHAIN = 3'h4
  } bsi_sel_t;

  typedef struct packed {
    bsi_sel_t sel;
    logic     test;
    logic     intest;
    logic     from_cells;
    logic     outs_off;
  } bsi_mode_t;

endpackage : bsi_pkg

// >>> src/bsi_top.sv
`timescale 1ns/10ps
// Contract
// R1: EXTEST code 0000 selects the cell chain and puts cells in test mode.
// R2: EXTEST capture takes pin inputs and values driven to output pins.
// R3: Shift moves captured chain bits to TDO while TDI fills the chain.
// R4: EXTEST or INTEST update loads output latches, applied at once.
// R5: SAMPLE/PRELOAD 0011 selects the chain, cells normal, snapshot on capture.
// R6: SAMPLE/PRELOAD update loads latches but does not drive core or pins.
// R7: CLAMP 0101 selects bypass, outputs driven from held chain values.
// R8: HIGHZ 0111 selects bypass, all output drivers disabled.
// R9: CLAMPZ 1001 selects bypass, drivers off, data still from cells.
// R10: INTEST 1100 captures inverted core inputs and true core outputs.
// R11: IDCODE 1110 selects the 32-bit identification register, cells normal.
// R12: Identification register loads code on capture, shifts, ignores update.
// R13: Identification word holds version, part, maker fields and a one.
// R14: BYPASS 1111 selects the bypass bit, pins untouched.
// R15: Bypass bit captures zero, delays TDI one cycle, ignores update.
// R16: Chain is serial path only for sample, extest, intest.
// R17: In normal mode cells pass core and pin signals straight through.
// R18: Every cell has an update latch; extra cells drive output enables.
// R19: Chain order starts at TDI; input cells can drive the core.
// R20: Chain contents undefined after power-up or test reset.
// R21: Controller preloads a guard pattern before test or clamp modes.
// R22: INTEST allows single stepping by repeated capture, shift, update.
// R23: Instruction register is four bits, captures 0001.
// R24: TDI and TMS sampled on rising TCK; TDO changes on falling TCK.
// R25: Power-on or five TMS-high clocks reset the port to IDCODE.
// R26: TDO driven only in shift states, otherwise released.
module bsi_top
  import bsi_pkg::*;
#(
  parameter int          N_IN     = 8,
  parameter int          N_OUT    = 8,
  parameter int          N_EN     = 2,
  // Identification values are arbitrary
  parameter logic [3:0]  ID_VER   = 4'h1,
  parameter logic [15:0] ID_PART  = 16'h0a5a,
  parameter logic [10:0] ID_MANUF = 11'h055
)
(
  // System clock and power-on reset
  input  logic             CLK_I,
  input  logic             RESET_I,
  // Test access port
  input  logic             TCK_I,
  input  logic             TMS_I,
  input  logic             TDI_I,
  output logic             TDO_O,
  output logic             TDO_OE_N_O,
  // Core side
  output logic [N_IN-1:0]  CORE_IN_O,
  input  logic [N_OUT-1:0] CORE_OUT_I,
  input  logic [N_EN-1:0]  CORE_OE_I,
  // Pin side
  input  logic [N_IN-1:0]  PIN_IN_I,
  output logic [N_OUT-1:0] PIN_OUT_O,
  output logic [N_EN-1:0]  PIN_OE_N_O
);
`include "bsi_map.svh"
  localparam int L = N_IN + N_OUT + N_EN;
  // ****************************************************************
  // Instruction decode
  // ****************************************************************
  function automatic bsi_mode_t mode_of(input logic [`BSI_IR_W-1:0] op);
    // Fields: sel, test, intest, from_cells, outs_off
    case (op)
      // R1: extest path
      `BSI_OP_EXTEST: return '{SEL_CHAIN, 1'b1, 1'b0, 1'b1, 1'b0};
      // R5: sample keeps normal
      `BSI_OP_SAMPLE: return '{SEL_CHAIN, 1'b0, 1'b0, 1'b0, 1'b0};
      // R7: clamp from cells
      `BSI_OP_CLAMP:  return '{SEL_BYP, 1'b0, 1'b0, 1'b1, 1'b0};
      // R8: all drivers off
      `BSI_OP_HIGHZ:  return '{SEL_BYP, 1'b0, 1'b0, 1'b0, 1'b1};
      // R9: drivers off, data kept
      `BSI_OP_CLAMPZ: return '{SEL_BYP, 1'b0, 1'b0, 1'b1, 1'b1};
      // R10: intest path
      `BSI_OP_INTEST: return '{SEL_CHAIN, 1'b1, 1'b1, 1'b1, 1'b0};
      // R11: identification path
      `BSI_OP_IDCODE: return '{SEL_ID, 1'b0, 1'b0, 1'b0, 1'b0};
      // R14: plain bypass, unknown codes fall back here
      default:        return '{SEL_BYP, 1'b0, 1'b0, 1'b0, 1'b0};
    endcase
  endfunction : mode_of
  // ****************************************************************
  // Test clock domain: controller
  // ****************************************************************
  bsi_tap_t                tap_reg;
  bsi_tap_t                tap_next;
  logic [`BSI_IR_W-1:0]    ir_sh_reg;
  logic [`BSI_IR_W-1:0]    ir_reg;
  logic                    byp_reg;
  logic [`BSI_ID_W-1:0]    id_sh_reg;
  logic [L-1:0]            chain_sh_reg;
  logic [L-1:0]            chain_upd_reg;
  logic [L-1:0]            cap_s1_reg;
  logic [L-1:0]            cap_s2_reg;
  logic                    xfer_tgl_reg;
  logic                    tdo_reg;
  logic                    tdo_oe_n_reg;
  bsi_mode_t               mode_t;
  logic [`BSI_ID_W-1:0]    id_word;
  logic [L-1:0]            cap_src_reg;
  assign mode_t = mode_of(ir_reg);
  // R13: identification word
  assign id_word = {ID_VER, ID_PART, ID_MANUF, `BSI_ID_FIXED};
  // R24: TMS sampled on rising edge
  always_comb
  begin
    case (tap_reg)
      TAP_RESET:  tap_next = TMS_I ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tap_next = TMS_I ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = TMS_I ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = TMS_I ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_next = TMS_I ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = TMS_I ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  tap_next = TMS_I ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_next = TMS_I ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = TMS_I ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = TMS_I ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = TMS_I ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_next = TMS_I ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = TMS_I ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  tap_next = TMS_I ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_next = TMS_I ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = TMS_I ? TAP_SEL_DR : TAP_IDLE;
      default:    tap_next = TAP_RESET;
    endcase
  end

  // R25: power-on and TMS reset
  always_ff @(posedge TCK_I or posedge RESET_I)
  begin
    if (RESET_I)
      tap_reg <= TAP_RESET;
    else
      tap_reg <= tap_next;
  end

  // R23: four-bit instruction shift
  always_ff @(posedge TCK_I or posedge RESET_I)
  begin
    if (RESET_I)
      ir_sh_reg <= `BSI_IR_CAPTURE;
    else if (tap_reg == TAP_CAP_IR)
      ir_sh_reg <= `BSI_IR_CAPTURE;
    else if (tap_reg == TAP_SH_IR)
      ir_sh_reg <= {TDI_I, ir_sh_reg[`BSI_IR_W-1:1]};
  end

  // R25: reset selects IDCODE
  always_ff @(posedge TCK_I or posedge RESET_I)
  begin
    if (RESET_I)
      ir_reg <= `BSI_OP_IDCODE;
    else if (tap_reg == TAP_RESET)
      ir_reg <= `BSI_OP_IDCODE;
    else if (tap_reg == TAP_UPD_IR)
      ir_reg <= ir_sh_reg;
  end

  // R15: bypass bit, no update
  always_ff @(posedge TCK_I or posedge RESET_I)
  begin
    if (RESET_I)
      byp_reg <= `BSI_BYP_CAPTURE;
    else if (tap_reg == TAP_CAP_DR && mode_t.sel == SEL_BYP)
      byp_reg <= `BSI_BYP_CAPTURE;
    else if (tap_reg == TAP_SH_DR && mode_t.sel == SEL_BYP)
      byp_reg <= TDI_I;
  end

  // R12: identification capture and shift
  always_ff @(posedge TCK_I or posedge RESET_I)
  begin
    if (RESET_I)
      id_sh_reg <= '0;
    else if (tap_reg == TAP_CAP_DR && mode_t.sel == SEL_ID)
      id_sh_reg <= id_word;
    else if (tap_reg == TAP_SH_DR && mode_t.sel == SEL_ID)
      id_sh_reg <= {TDI_I, id_sh_reg[`BSI_ID_W-1:1]};
  end

  // Capture source crosses as slow, quasi-static levels
  always_ff @(posedge TCK_I or posedge RESET_I)
  begin
    if (RESET_I)
      {cap_s2_reg, cap_s1_reg} <= {(2*L){1'b0}};
    else
      {cap_s2_reg, cap_s1_reg} <= {cap_s1_reg, cap_src_reg};
  end

  // R19: input cells sit nearest TDI
  // R3: capture then shift toward TDO
  always_ff @(posedge TCK_I or posedge RESET_I)
  begin
    if (RESET_I)
      chain_sh_reg <= '0;
    else if (tap_reg == TAP_CAP_DR && mode_t.sel == SEL_CHAIN)
      chain_sh_reg <= cap_s2_reg;
    else if (tap_reg == TAP_SH_DR && mode_t.sel == SEL_CHAIN)
      chain_sh_reg <= {TDI_I, chain_sh_reg[L-1:1]};
  end

  // R20: reset value is only a convenience
  // R16: untouched unless chain selected
  // R22: each update is one step
  always_ff @(posedge TCK_I or posedge RESET_I)
  begin
    if (RESET_I)
      chain_upd_reg <= '0;
    else if (tap_reg == TAP_UPD_DR && mode_t.sel == SEL_CHAIN)
      chain_upd_reg <= chain_sh_reg;
  end

  // Toggle tells the system side that mode or latches moved
  always_ff @(posedge TCK_I or posedge RESET_I)
  begin
    if (RESET_I)
      xfer_tgl_reg <= 1'b0;
    else if (tap_reg == TAP_UPD_DR || tap_reg == TAP_UPD_IR ||
             (tap_reg == TAP_RESET && ir_reg != `BSI_OP_IDCODE))
      xfer_tgl_reg <= ~xfer_tgl_reg;
  end

  // R24: TDO moves on falling edge
  // R26: driven only while shifting
  always_ff @(negedge TCK_I or posedge RESET_I)
  begin
    if (RESET_I)
      {tdo_reg, tdo_oe_n_reg} <= 2'h1;
    else
    begin
      tdo_oe_n_reg <= !(tap_reg == TAP_SH_DR || tap_reg == TAP_SH_IR);
      if (tap_reg == TAP_SH_IR)
        tdo_reg <= ir_sh_reg[0];
      else if (tap_reg == TAP_SH_DR)
      begin
        case (mode_t.sel)
          SEL_ID:    tdo_reg <= id_sh_reg[0];
          SEL_CHAIN: tdo_reg <= chain_sh_reg[0];
          default:   tdo_reg <= byp_reg;
        endcase
      end
    end
  end

  assign TDO_O      = tdo_reg;
  assign TDO_OE_N_O = tdo_oe_n_reg;

  // ****************************************************************
  // System clock domain: cells
  // ****************************************************************
  logic [2:0]            tgl_sync_reg;
  logic [`BSI_IR_W-1:0]  ir_c_reg;
  logic [L-1:0]          upd_c_reg;
  logic [N_IN-1:0]       pin_s1_reg;
  logic [N_IN-1:0]       pin_s2_reg;
  logic [N_IN-1:0]       core_in_reg;
  logic [N_OUT-1:0]      pin_out_reg;
  logic [N_EN-1:0]       pin_oe_n_reg;
  bsi_mode_t             mode_c;
  logic [N_IN-1:0]       upd_in;
  logic [N_OUT-1:0]      upd_out;
  logic [N_EN-1:0]       upd_en;

  assign mode_c  = mode_of(ir_c_reg);
  assign upd_in  = upd_c_reg[L-1 -: N_IN];
  assign upd_out = upd_c_reg[N_EN +: N_OUT];
  assign upd_en  = upd_c_reg[N_EN-1:0];

  // Bit 0 is only the first stage; edge logic looks at bits 2 and 1
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      tgl_sync_reg <= '0;
    else
      tgl_sync_reg <= {tgl_sync_reg[1:0], xfer_tgl_reg};
  end

  // Latched words are stable for many clocks around each toggle
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      {ir_c_reg, upd_c_reg} <= {`BSI_OP_IDCODE, {L{1'b0}}};
    else if (tgl_sync_reg[2] != tgl_sync_reg[1])
      {ir_c_reg, upd_c_reg} <= {ir_reg, chain_upd_reg};
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      {pin_s2_reg, pin_s1_reg} <= {(2*N_IN){1'b0}};
    else
      {pin_s2_reg, pin_s1_reg} <= {pin_s1_reg, PIN_IN_I};
  end

  // R17: straight through in normal mode
  // R19: input cells drive the core in test
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      core_in_reg <= '0;
    else if (mode_c.test)
      core_in_reg <= upd_in;
    else
      core_in_reg <= pin_s2_reg;
  end

  // R4: test latches drive pins
  // R6: sample keeps core data
  // R7: clamp holds chain data
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      pin_out_reg <= '0;
    else if (mode_c.from_cells)
      pin_out_reg <= upd_out;
    else
      pin_out_reg <= CORE_OUT_I;
  end

  // R18: enable cells steer drivers
  // R8: drivers released
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      pin_oe_n_reg <= '1;
    else if (mode_c.outs_off)
      pin_oe_n_reg <= '1;
    else if (mode_c.from_cells)
      pin_oe_n_reg <= ~upd_en;
    else
      pin_oe_n_reg <= ~CORE_OE_I;
  end

  // R2: pin side capture
  // R10: core side capture, inputs inverted
  // R5: sample snapshot of cells
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      cap_src_reg <= '0;
    else if (mode_c.intest)
      cap_src_reg <= {~core_in_reg, CORE_OUT_I, CORE_OE_I};
    else
      cap_src_reg <= {pin_s2_reg, pin_out_reg, ~pin_oe_n_reg};
  end
  assign CORE_IN_O  = core_in_reg;
  assign PIN_OUT_O  = pin_out_reg;
  assign PIN_OE_N_O = pin_oe_n_reg;
  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_ir_capture: assert property ( // R23
    @(posedge TCK_I) disable iff (RESET_I)
    tap_reg == TAP_CAP_IR |=> ir_sh_reg == `BSI_IR_CAPTURE)
    else $error("instruction capture value wrong");
  chk_tms_reset: assert property ( // R25
    @(posedge TCK_I) disable iff (RESET_I)
    TMS_I [*5] |=> tap_reg == TAP_RESET ##1 ir_reg == `BSI_OP_IDCODE)
    else $error("five TMS-high clocks did not reset");
  chk_byp_capture: assert property ( // R15
    @(posedge TCK_I) disable iff (RESET_I)
    tap_reg == TAP_CAP_DR && mode_t.sel == SEL_BYP
    |=> byp_reg == 1'b0)
    else $error("bypass did not capture zero");
  chk_byp_shift: assert property ( // R15
    @(posedge TCK_I) disable iff (RESET_I)
    tap_reg == TAP_SH_DR && mode_t.sel == SEL_BYP
    |=> byp_reg == $past(TDI_I))
    else $error("bypass did not delay TDI one cycle");
  chk_id_capture: assert property ( // R12
    @(posedge TCK_I) disable iff (RESET_I)
    tap_reg == TAP_CAP_DR && mode_t.sel == SEL_ID
    |=> id_sh_reg[0] == 1'b1 && id_sh_reg == id_word)
    else $error("identification word not captured");
  chk_upd_guard: assert property ( // R16
    @(posedge TCK_I) disable iff (RESET_I)
    tap_reg == TAP_UPD_DR && mode_t.sel != SEL_CHAIN
    |=> $stable(chain_upd_reg))
    else $error("update latches changed off the chain path");
  // Enable was set on the falling edge from the state seen here
  chk_tdo_release: assert property ( // R26
    @(posedge TCK_I) disable iff (RESET_I)
    tap_reg != TAP_SH_DR && tap_reg != TAP_SH_IR
    |-> tdo_oe_n_reg)
    else $error("TDO driven outside shift states");
  chk_highz_pins: assert property ( // R8
    @(posedge CLK_I) disable iff (RESET_I)
    mode_c.outs_off |=> pin_oe_n_reg == '1)
    else $error("output drivers not released");
  chk_normal_pass: assert property ( // R17
    @(posedge CLK_I) disable iff (RESET_I)
    !mode_c.from_cells [*2] |-> pin_out_reg == $past(CORE_OUT_I))
    else $error("normal mode does not pass core outputs");
endmodule : bsi_top

// >>> test/bsi_tap_ctl.sv
`timescale 1ns/10ps
// ****************************
// Test controller model
// ****************************
module bsi_tap_ctl
(
  // Test access port
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  // Device answer
  input  logic tdo_i,
  input  logic tdo_oe_n_i
);
  // Clock stands still low between frames
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #16;
    // No pull-up on TDO: a released pin reads back inverted
    tdo = tdo_oe_n_i ? ~tdo_i : tdo_i;
    tck_o = 1'b1;
    #32;
    tck_o = 1'b0;
    #16;
  endtask : step

  task automatic tap_reset();
    logic t;
    repeat (5) step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
  endtask : tap_reset

  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic oe_ok);
    logic t;
    dout = 32'h0;
    oe_ok = 1'b1;
    step(1'b1, 1'b0, t);
    if (ir)
      step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
    step(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++)
    begin
      oe_ok &= (tdo_oe_n_i === 1'b0);
      step(i == n - 1, din[i], dout[i]);
    end
    step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
  endtask : scan
endmodule : bsi_tap_ctl

// >>> test/tb_boundary_scan_instructions.sv
`timescale 1ns/10ps
`include "bsi_map.svh"
module tb_boundary_scan_instructions;
  // ****************************
  // Setup
  // ****************************
  // Identification values are arbitrary
  localparam logic [3:0]  VER  = 4'h3;
  localparam logic [15:0] PART = 16'h1234;
  localparam logic [10:0] MAN  = 11'h2a1;
  localparam logic [31:0] ID   = {VER, PART, MAN, `BSI_ID_FIXED};
  localparam logic [17:0] P    = 18'h2c93e;
  localparam logic [17:0] Q    = 18'h1a5c3;
  localparam logic [17:0] R    = 18'h3f00d;
  logic        clk;
  logic        rst;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdo_oe_n;
  logic [7:0]  core_in;
  logic [7:0]  core_out;
  logic [7:0]  pin_in;
  logic [7:0]  pin_out;
  logic [1:0]  core_oe;
  logic [1:0]  pin_oe_n;
  logic [31:0] d;
  int          miscompares;
  int          checks_done;

  bsi_top #(.ID_VER(VER), .ID_PART(PART), .ID_MANUF(MAN)) dut
  (
    .CLK_I(clk), .RESET_I(rst),
    .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
    .TDO_O(tdo), .TDO_OE_N_O(tdo_oe_n),
    .CORE_IN_O(core_in), .CORE_OUT_I(core_out), .CORE_OE_I(core_oe),
    .PIN_IN_I(pin_in), .PIN_OUT_O(pin_out), .PIN_OE_N_O(pin_oe_n)
  );

  bsi_tap_ctl ctl
  (
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
    .tdo_i(tdo), .tdo_oe_n_i(tdo_oe_n)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************
  // Helpers
  // ****************************
  task automatic chk(input string what, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  // Pins cross two clock domains, so allow margin
  task automatic settle();
    repeat (12) @(posedge clk);
    #1;
  endtask : settle

  task automatic set_io(input logic [7:0] a, b, input logic [1:0] c);
    @(posedge clk);
    #1;
    pin_in = a;
    core_out = b;
    core_oe = c;
    settle();
  endtask : set_io

  task automatic pins(input logic [7:0] ci, po, input logic [1:0] oen);
    chk("core in", {24'h0, ci}, {24'h0, core_in});
    chk("pin out", {24'h0, po}, {24'h0, pin_out});
    chk("pin oe_n", {30'h0, oen}, {30'h0, pin_oe_n});
  endtask : pins

  task automatic do_scan(input logic ir, input int n, input logic [31:0] din,
                         output logic [31:0] dout);
    logic ok;
    ctl.scan(ir, n, din, dout, ok);
    chk("tdo on in shift", 32'h1, {31'h0, ok});
    chk("tdo off in idle", 32'h1, {31'h0, tdo_oe_n});
  endtask : do_scan

  task automatic load_ir(input logic [3:0] op);
    do_scan(1'b1, 4, {28'h0, op}, d);
    chk("ir capture", {28'h0, `BSI_IR_CAPTURE}, d);
    settle();
  endtask : load_ir

  // ****************************
  // Scenarios
  // ****************************
  task automatic t_idcode();
    do_scan(1'b0, 32, 32'hffff0000, d);
    chk("id word", ID, d);
    do_scan(1'b0, 32, 32'h0, d);
    chk("id after update", ID, d);
    pins(pin_in, core_out, ~core_oe);
  endtask : t_idcode

  task automatic t_sample();
    set_io(8'ha5, 8'h3c, 2'h2);
    load_ir(`BSI_OP_SAMPLE);
    do_scan(1'b0, 18, {14'h0, P}, d);
    chk("sample capture", {14'h0, 8'ha5, 8'h3c, 2'h2}, d);
    settle();
    pins(pin_in, core_out, ~core_oe);
  endtask : t_sample

  task automatic t_extest();
    load_ir(`BSI_OP_EXTEST);
    pins(P[17:10], P[9:2], ~P[1:0]);
    set_io(8'h5a, 8'hc3, 2'h1);
    do_scan(1'b0, 18, {14'h0, Q}, d);
    chk("extest capture", {14'h0, 8'h5a, P[9:2], P[1:0]}, d);
    settle();
    pins(Q[17:10], Q[9:2], ~Q[1:0]);
  endtask : t_extest

  task automatic t_intest();
    load_ir(`BSI_OP_INTEST);
    pins(Q[17:10], Q[9:2], ~Q[1:0]);
    do_scan(1'b0, 18, {14'h0, R}, d);
    chk("intest capture", {14'h0, ~Q[17:10], 8'hc3, 2'h1}, d);
    settle();
    pins(R[17:10], R[9:2], ~R[1:0]);
  endtask : t_intest

  // Chain holds R here; bypass scans must leave it alone
  task automatic t_modes();
    logic [3:0] ops [5] = '{`BSI_OP_CLAMP, `BSI_OP_HIGHZ, `BSI_OP_CLAMPZ,
                            `BSI_OP_BYPASS, 4'h2};
    foreach (ops[i])
    begin
      load_ir(ops[i]);
      do_scan(1'b0, 4, 32'hb, d);
      chk("bypass path", 32'h6, d);
      settle();
      case (ops[i])
        `BSI_OP_CLAMP:  pins(pin_in, R[9:2], ~R[1:0]);
        `BSI_OP_HIGHZ:  pins(pin_in, core_out, 2'h3);
        `BSI_OP_CLAMPZ: pins(pin_in, R[9:2], 2'h3);
        default:        pins(pin_in, core_out, ~core_oe);
      endcase
    end
  endtask : t_modes

  task automatic t_tmsreset();
    load_ir(`BSI_OP_CLAMP);
    ctl.tap_reset();
    settle();
    pins(pin_in, core_out, ~core_oe);
    do_scan(1'b0, 32, 32'h0, d);
    chk("id after tms reset", ID, d);
  endtask : t_tmsreset

  // ****************************
  // Main sequence
  // ****************************
  initial
  begin
    rst = 1'b0;
    pin_in = 8'h0f;
    core_out = 8'h96;
    core_oe = 2'h1;
    miscompares = 0;
    checks_done = 0;
    // A clean rising reset edge, so the idle test clock flops start known
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    ctl.tap_reset();
    t_idcode();
    t_sample();
    t_extest();
    t_intest();
    t_modes();
    t_tmsreset();
    stop_test();
  end

  // Hang guard
  initial
  begin
    #200000;
    miscompares++;
    stop_test();
  end
endmodule : tb_boundary_scan_instructions
